// [pss_array.v]
`timescale 1ns/1ps
`default_nettype none
module pss_array #(
  parameter AW = 16,
  parameter LW = 9,
  parameter NL = 2
) (
  // Clock
  input  wire                ref_clk_i,
  // Access
  input  wire [AW-1:0]       addr_i,
  input  wire [NL-1:0]       lane_we_i,
  input  wire [NL*LW-1:0]    wdata_i,
  output reg  [NL*LW-1:0]    rdata_o
);
  reg [NL*LW-1:0] mem [0:(1<<AW)-1];
  genvar g;
  // Per-lane write, registered read
  generate
    for (g = 0; g < NL; g = g + 1) begin : lane
      always @(posedge ref_clk_i) begin
        if (lane_we_i[g]) begin
          mem[addr_i][g*LW +: LW] <= wdata_i[g*LW +: LW];
        end
      end
    end
  endgenerate
  always @(posedge ref_clk_i) begin
    rdata_o <= mem[addr_i];
  end
endmodule
`default_nettype wire

// [pss_bus_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pss_bus_master_model (
  // Device and master drivers
  input  wire logic [17:0] dev_d_i, dev_oe_i, mst_d_i,
  input  wire logic        mst_oe_i,
  // Level on the shared lines
  output var  logic [17:0] bus_o
);
  logic [17:0] last = 18'h0;
  // Released lines flip, so a stale copy never passes
  always @* begin
    if (mst_oe_i) last = mst_d_i;
    else if (dev_oe_i[0]) last = dev_d_i;
    bus_o = mst_oe_i ? mst_d_i : (dev_oe_i & dev_d_i) | (~dev_oe_i & ~last);
  end
endmodule
`default_nettype wire

// [pss_core.v]
`timescale 1ns/1ps
`default_nettype none
`include "pss_map.vh"
module pss_core #(
  parameter AW = `PSS_ADDR_W,
  parameter LW = `PSS_LANE_W,
  parameter NL = `PSS_LANES
) (
  // Clock and reset
  input  wire                ref_clk_i,
  input  wire                rst_i,
  // Address and strobes
  input  wire [AW-1:0]       addr_i,
  input  wire                proc_addr_strobe_n_i,
  input  wire                ctrl_addr_strobe_n_i,
  input  wire                burst_advance_n_i,
  // Chip selects
  input  wire                chip_sel_pipe_n_i,
  input  wire                chip_sel_depth_hi_i,
  input  wire                chip_sel_depth_lo_n_i,
  // Write controls
  input  wire [NL-1:0]       lane_write_sel_n_i,
  input  wire                lane_write_enable_n_i,
  input  wire                all_lanes_write_n_i,
  // Output enable and strap, asynchronous pins
  input  wire                out_enable_n_i,
  input  wire                burst_order_i,
  // Data lines, split three ways
  input  wire [NL*LW-1:0]    dq_i,
  output reg  [NL*LW-1:0]    dq_o,
  output reg  [NL*LW-1:0]    dq_oe_o
);
  localparam BW = `PSS_BURST_W;

  // Input registers on every rising edge
  reg [AW-1:0]    a_q;
  reg             proc_addr_strobe_n_q, ctrl_addr_strobe_n_q, adv_q, ce1_q, ce2_q, ce3_q, bwe_q, gw_q;
  reg [NL-1:0]    bw_q;
  reg [NL*LW-1:0] din_q;
  reg             oe_s1, oe_s2, mode_s1, mode_s2;
  always @(posedge ref_clk_i) begin
    a_q    <= addr_i;
    proc_addr_strobe_n_q <= proc_addr_strobe_n_i;
    ctrl_addr_strobe_n_q <= ctrl_addr_strobe_n_i;
    adv_q  <= burst_advance_n_i;
    ce1_q  <= chip_sel_pipe_n_i;
    ce2_q  <= chip_sel_depth_hi_i;
    ce3_q  <= chip_sel_depth_lo_n_i;
    bw_q   <= lane_write_sel_n_i;
    bwe_q  <= lane_write_enable_n_i;
    gw_q   <= all_lanes_write_n_i;
    din_q  <= dq_i;
    // Asynchronous pins pass two stages before use
    oe_s1   <= out_enable_n_i;
    oe_s2   <= oe_s1;
    mode_s1 <= burst_order_i;
    mode_s2 <= mode_s1;
  end

  // Lane write decode, used for strobed and burst cycles
  function [NL-1:0] lane_wr;
    input          gw_n;
    input          bwe_n;
    input [NL-1:0] sel_n;
    begin
      if (!gw_n) begin
        lane_wr = {NL{1'b1}};
      end else if (!bwe_n) begin
        lane_wr = ~sel_n;
      end else begin
        lane_wr = {NL{1'b0}};
      end
    end
  endfunction

  // Burst address from base and step count
  function [BW-1:0] burst_lsb;
    input          lin;
    input [BW-1:0] base;
    input [BW-1:0] step;
    begin
      if (lin) begin
        burst_lsb = base + step;
      end else begin
        burst_lsb = base ^ step;
      end
    end
  endfunction

  // Select and strobe qualification
  wire sel_ok   = !ce1_q && ce2_q && !ce3_q;
  wire p_strobe = !proc_addr_strobe_n_q && !ce1_q;
  // Controller strobe counts unless a processor strobe is taken; a blocked one does not mask it
  wire c_strobe = !ctrl_addr_strobe_n_q && !p_strobe;
  wire strobe   = p_strobe || c_strobe;
  wire load_sel = strobe && sel_ok;
  wire deselect = strobe && !sel_ok;
  wire linear   = (mode_s2 == `PSS_ORDER_LINEAR);

  // Address register, burst base and step, active flag
  reg [AW-1:0] addr_hold;
  reg [BW-1:0] base, step;
  reg          active;
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      addr_hold <= {AW{1'b0}};
      base      <= {BW{1'b0}};
      step      <= {BW{1'b0}};
      active    <= 1'b0;
    end else if (strobe) begin
      active <= sel_ok;
      if (sel_ok) begin
        addr_hold <= a_q;
        base      <= a_q[BW-1:0];
        step      <= {BW{1'b0}};
      end
    end else if (active && !adv_q) begin
      step <= step + 2'h1;
    end
  end

  // Current array address: fresh load or burst position
  wire [AW-1:0] cur_addr = load_sel ? a_q :
                           {addr_hold[AW-1:BW], burst_lsb(linear, base, step + 2'h1)};
  wire          cur_go   = load_sel || (active && !strobe && !adv_q);
  // Processor strobe cycle is always a read; writes come with the next cycle
  wire [NL-1:0] wr_lanes = (cur_go && !(load_sel && p_strobe)) ?
                           lane_wr(gw_q, bwe_q, bw_q) : {NL{1'b0}};
  reg           rd_go;
  always @* begin
    rd_go = cur_go && (wr_lanes == {NL{1'b0}});
  end

  // Hold: keep current burst address when no advance
  wire [AW-1:0] hold_addr = {addr_hold[AW-1:BW], burst_lsb(linear, base, step)};
  wire          hold_wr   = active && !strobe && adv_q;
  wire [NL-1:0] hold_lanes = hold_wr ? lane_wr(gw_q, bwe_q, bw_q) : {NL{1'b0}};
  wire [AW-1:0] arr_addr  = cur_go ? cur_addr : hold_addr;
  wire [NL-1:0] arr_we    = cur_go ? wr_lanes : hold_lanes;

  // Self-timed array write and registered read
  wire [NL*LW-1:0] arr_rdata;
  pss_array #(
    .AW (AW),
    .LW (LW),
    .NL (NL)
  ) u_array (
    .ref_clk_i (ref_clk_i),
    .addr_i    (arr_addr),
    .lane_we_i (arr_we),
    .wdata_i   (din_q),
    .rdata_o   (arr_rdata)
  );

  // Pipeline of read valid and the extra deselect enable stage
  reg rd_v1, rd_v2, first_v1, first_v2, dcd_hold, was_desel;
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      rd_v1     <= 1'b0;
      rd_v2     <= 1'b0;
      first_v1  <= 1'b0;
      first_v2  <= 1'b0;
      dcd_hold  <= 1'b0;
      was_desel <= 1'b1;
    end else begin
      rd_v1    <= rd_go || (hold_wr && hold_lanes == {NL{1'b0}});
      rd_v2    <= rd_v1;
      first_v1 <= load_sel && was_desel;
      first_v2 <= first_v1;
      // Buffers stay on one more cycle after a deselect
      dcd_hold <= rd_v2 && !rd_v1;
      if (deselect) begin
        was_desel <= 1'b1;
      end else if (load_sel) begin
        was_desel <= 1'b0;
      end
    end
  end

  // Array data held one stage so it meets rd_v2; without it a burst skips its first word
  reg [NL*LW-1:0] rd_pipe;
  always @(posedge ref_clk_i) begin
    rd_pipe <= arr_rdata;
  end

  // Output register and direction control
  wire drive = (rd_v2 && (!oe_s2 || first_v2)) || (dcd_hold && !oe_s2);
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      dq_o    <= {NL*LW{1'b0}};
      dq_oe_o <= {NL*LW{1'b0}};
    end else begin
      if (rd_v2) begin
        dq_o <= rd_pipe;
      end
      dq_oe_o <= {NL*LW{drive}};
    end
  end
endmodule
`default_nettype wire

// [pss_core_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module pss_core_monitor (
  // Clock, reset and control pins
  input wire logic        ref_clk_i, rst_i, proc_addr_strobe_n_i, ctrl_addr_strobe_n_i,
  input wire logic        burst_advance_n_i, chip_sel_pipe_n_i, chip_sel_depth_hi_i,
  input wire logic        chip_sel_depth_lo_n_i, lane_write_enable_n_i, all_lanes_write_n_i,
  input wire logic        out_enable_n_i,
  input wire logic [1:0]  lane_write_sel_n_i,
  // Data drive enables
  input wire logic [17:0] dq_oe_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Decoded request kinds
  wire sel = !chip_sel_pipe_n_i && chip_sel_depth_hi_i && !chip_sel_depth_lo_n_i;
  wire wr = !all_lanes_write_n_i || (!lane_write_enable_n_i && !(&lane_write_sel_n_i));
  wire quiet = proc_addr_strobe_n_i && ctrl_addr_strobe_n_i && burst_advance_n_i;
  wire rd = sel && (!proc_addr_strobe_n_i || (!ctrl_addr_strobe_n_i && !wr));
  wire on = &dq_oe_o;
  wire oel = !out_enable_n_i;
  wire off = quiet && !oel;
  wire blk = !proc_addr_strobe_n_i && ctrl_addr_strobe_n_i && chip_sel_pipe_n_i;
  wire desel = proc_addr_strobe_n_i && !ctrl_addr_strobe_n_i && !sel;
  wire held = quiet && !wr && oel && on;
  property p_oe_same; dq_oe_o == 18'h0 || on; endproperty
  a_oe_same: assert property (p_oe_same) else $error("drive enables differ");
  property p_rst_quiet; disable iff (1'b0) rst_i |=> dq_oe_o == 18'h0; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("driving in reset");
  property p_read_lat; oel[*3] ##0 rd ##1 (quiet && oel)[*3] |=> on; endproperty
  a_read_lat: assert property (p_read_lat) else $error("read word late");
  property p_dcd; held[*4] ##1 (desel && oel && on) ##1 (quiet && oel)[*3] |=> on; endproperty
  a_dcd: assert property (p_dcd) else $error("drive dropped early");
  property p_ce1_block;
    held[*4] ##1 (blk && !wr && burst_advance_n_i && oel && on) ##1 (quiet && !wr && oel)[*3] |=> on;
  endproperty
  a_ce1_block: assert property (p_ce1_block) else $error("blocked strobe acted");
  property p_unsel;
    off[*7] ##1 (proc_addr_strobe_n_i && !ctrl_addr_strobe_n_i && !sel && !oel)
      ##1 off[*3] |-> dq_oe_o == 18'h0;
  endproperty
  a_unsel: assert property (p_unsel) else $error("unselected strobe acted");
  property p_oe_off; off[*7] |-> dq_oe_o == 18'h0; endproperty
  a_oe_off: assert property (p_oe_off) else $error("driving with enable high");
  property p_proc_wins;
    oel[*3] ##0 (sel && !proc_addr_strobe_n_i && !ctrl_addr_strobe_n_i && !all_lanes_write_n_i)
      ##1 (quiet && oel)[*3] |=> on;
  endproperty
  a_proc_wins: assert property (p_proc_wins) else $error("processor strobe lost");
  // Main scenarios reached
  c_read: cover property (rd);
  c_write: cover property (sel && !ctrl_addr_strobe_n_i && wr);
  c_block: cover property (!proc_addr_strobe_n_i && chip_sel_pipe_n_i);
endmodule
bind pss_core pss_core_monitor pss_core_monitor_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .proc_addr_strobe_n_i(proc_addr_strobe_n_i), .ctrl_addr_strobe_n_i(ctrl_addr_strobe_n_i),
  .burst_advance_n_i(burst_advance_n_i), .chip_sel_pipe_n_i(chip_sel_pipe_n_i),
  .chip_sel_depth_hi_i(chip_sel_depth_hi_i), .chip_sel_depth_lo_n_i(chip_sel_depth_lo_n_i),
  .lane_write_enable_n_i(lane_write_enable_n_i), .all_lanes_write_n_i(all_lanes_write_n_i),
  .out_enable_n_i(out_enable_n_i), .lane_write_sel_n_i(lane_write_sel_n_i), .dq_oe_o(dq_oe_o));
`default_nettype wire

// [pss_map.vh]
// What this block does
// - Every synchronous input is captured in input registers on the rising clock edge.
// - Address and chip enables load only when a strobe is sampled active.
// - A two-bit burst counter makes following word addresses internally.
// - A load seeds the counter from address bits one and zero; upper bits held.
// - Counter steps once per edge with advance low, otherwise holds.
// - Writes are registered, then completed internally as a self-timed cycle.
// - Writes cover one or both byte lanes, chosen by the lane selects.
// - Global write low writes all lanes regardless of lane selects and enable.
// - Otherwise a lane writes only when lane enable and that lane's select are both low.
// - Output buffers stay enabled one extra cycle after a deselect.
// - Processor strobe is ignored while the first chip enable is high.
// - Selected only with enable one low, enable two high, enable three low.
// - A 16-bit address selects one of 64K words, each 18 bits wide.
// - Registered in and out: first word after three clocks, then one per clock.
// - Two burst orders, interleaved and linear, chosen by a user setting.
// - With both strobes low and enable one low, only the processor strobe is acted on.
// - Order strap low gives linear, high gives interleaved; strap stays static.
// - Output enable is ignored in the first clock of a read from deselect.
// - Read data driven only while output enable low, or in the first clock of a read from deselect; otherwise lines are inputs.
`ifndef PSS_MAP_VH
`define PSS_MAP_VH
`define PSS_ADDR_W   16
`define PSS_DATA_W   18
`define PSS_LANE_W   9
`define PSS_LANES    2
`define PSS_BURST_W  2
`define PSS_ORDER_LINEAR 1'h0
`endif

// [tb_pss_core.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_pss_core;
  logic clk = 0, rst = 1, p_n = 1, c_n = 1, adv_n = 1, ce1_n = 0, ce2 = 1, ce3_n = 0;
  logic bwe_n = 1, gw_n = 1, oe_n = 0, ord = 0, m_oe = 0;
  logic [1:0] sel_n = 2'h3;
  logic [15:0] addr = 16'h0;
  logic [17:0] m_d = 18'h0, dq_i, dq_o, dq_oe;
  logic [17:0] mem [int];
  int seed = 45767, bad_count = 0, tests_run = 0, cyc = 0;
  pss_core pss_core_inst (.ref_clk_i(clk), .rst_i(rst), .addr_i(addr), .proc_addr_strobe_n_i(p_n),
    .ctrl_addr_strobe_n_i(c_n), .burst_advance_n_i(adv_n), .chip_sel_pipe_n_i(ce1_n),
    .chip_sel_depth_hi_i(ce2), .chip_sel_depth_lo_n_i(ce3_n), .lane_write_sel_n_i(sel_n),
    .lane_write_enable_n_i(bwe_n), .all_lanes_write_n_i(gw_n), .out_enable_n_i(oe_n),
    .burst_order_i(ord), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe));
  pss_bus_master_model pss_bus_master_model_inst (.dev_d_i(dq_o), .dev_oe_i(dq_oe),
    .mst_d_i(m_d), .mst_oe_i(m_oe), .bus_o(dq_i));
  always #10 clk = ~clk;
  // Hang guard, far above the planned run
  always @(posedge clk) if (++cyc > 20000) begin
    bad_count++;
    end_sim();
  end
  task automatic chk(input string n, input logic [17:0] s, e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [1:0] nx(logic [1:0] b, int k);
    return ord ? b ^ k[1:0] : b + k[1:0];
  endfunction
  task automatic idle(int n);
    repeat (n) begin
      @(negedge clk);
      {p_n, c_n, adv_n, gw_n, bwe_n, ce2, m_oe, ce1_n, sel_n} = 10'h3f3;
    end
  endtask
  // One strobed write; lanes need global write low, or enable and select both low
  task automatic wr(logic [15:0] a, logic [17:0] d, logic g, b, logic [1:0] s);
    @(negedge clk);
    {addr, c_n, gw_n, bwe_n, sel_n, m_d, m_oe} = {a, 1'b0, g, b, s, d, 1'b1};
    if (!g || (!b && !s[0])) mem[a][8:0] = d[8:0];
    if (!g || (!b && !s[1])) mem[a][17:9] = d[17:9];
  endtask
  // Read, optionally a full burst; processor strobe comes with global write low
  task automatic rd(logic [15:0] a, logic p, bu);
    @(negedge clk);
    {addr, c_n, p_n, gw_n} = {a, 1'b0, !p, !p};
    for (int k = 0; k < 7; k++) begin
      @(negedge clk);
      {p_n, c_n, gw_n, adv_n} = {3'h7, k > 2 || !bu};
      if (k > 2) chk("read word", dq_o, mem[{a[15:2], nx(a[1:0], bu ? k - 3 : 0)}]);
      if (k == 3 || (k > 2 && bu)) chk("read drive", dq_oe, 18'h3ffff);
    end
  endtask
  // Blocked or unselected strobe; drive seen in the extra-cycle window, then after it
  task automatic probe(logic p, logic [17:0] e);
    @(negedge clk);
    {p_n, ce1_n, c_n, ce2} = {!p, p, p, p};
    idle(4);
    chk("probe drive", dq_oe, e);
    idle(2);
    chk("probe settled", dq_oe, p ? 18'h3ffff : 18'h0);
    idle(4);
  endtask
  initial begin
    logic [15:0] base;
    for (int o = 0; o < 2; o++) begin
      rst = 1;
      ord = o[0];
      repeat (10) @(negedge clk);
      rst = 0;
      idle(2);
      for (int t = 0; t < 8; t++) begin
        base = 16'($random(seed));
        for (int k = 0; k < 4; k++) wr({base[15:2], k[1:0]}, 18'($random(seed)), 0, 1, 3);
        idle(1);
        rd(base, t[0], t[1]);
        $display("burst test %0d order %0d done", t, o);
      end
      wr(base, 18'h3ffff, 0, 1, 2'h3);
      wr(base, 18'h0, 1, 0, 2'h2);
      wr(base, 18'h0, 1, 1, 2'h0);
      idle(1);
      rd(base, 0, 0);
      $display("lane write test order %0d done", o);
      oe_n = 1;
      idle(8);
      chk("drive with enable high", dq_oe, 18'h0);
      oe_n = 0;
      idle(8);
      probe(1, 18'h3ffff);
      probe(0, 18'h3ffff);
      oe_n = 1;
      idle(8);
      probe(0, 18'h0);
      oe_n = 0;
      $display("select probe test order %0d done", o);
    end
    end_sim();
  end
endmodule
`default_nettype wire
